/* File: sample_clock_pkg.sv */
// constants, register map and carrier types for the sample clock selector
// assumes a single 125 MHz clock and an apb master with 32-bit data
package sample_clock_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 125_000_000;
    // dds accumulator gain: increment per hz for a 40-bit phase word
    localparam logic [39:0] DDS_GAIN = 40'((64'h0000_0000_0000_0001 << 40) / CLK_HZ);
    // boundaries between rate classes, fastest first, in hz
    localparam longint unsigned CLS_HZ [7] = '{184000, 124000, 92000, 62500, 46000, 37000, 27800};
    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] CLS_CYC [7] = '{
        CNT_W'(CLK_HZ / CLS_HZ[0]), CNT_W'(CLK_HZ / CLS_HZ[1]), CNT_W'(CLK_HZ / CLS_HZ[2]),
        CNT_W'(CLK_HZ / CLS_HZ[3]), CNT_W'(CLK_HZ / CLS_HZ[4]), CNT_W'(CLK_HZ / CLS_HZ[5]),
        CNT_W'(CLK_HZ / CLS_HZ[6])};

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_RATE  = 8'h04;
    localparam logic [7:0] ADDR_PITCH = 8'h08;
    localparam logic [7:0] ADDR_PCMD  = 8'h0c;
    localparam logic [7:0] ADDR_INPUT = 8'h10;
    localparam logic [7:0] ADDR_CUR   = 8'h14;
    localparam logic [7:0] ADDR_CSTAT = 8'h18;
    localparam logic [7:0] ADDR_IST   = 8'h1c;
    localparam logic [7:0] ADDR_ICLR  = 8'h20;
    localparam logic [7:0] ADDR_IEN   = 8'h24;

    // pitch command bits
    localparam int PC_COARSE_UP = 0;
    localparam int PC_COARSE_DN = 1;
    localparam int PC_FINE_UP   = 2;
    localparam int PC_FINE_DN   = 3;
    localparam int PC_RESET     = 4;
    localparam int PC_UP_0P1    = 5;
    localparam int PC_DN_0P1    = 6;
    localparam int PC_UP_4      = 7;
    localparam int PC_DN_4      = 8;

    // event bits
    localparam int EV_SRC  = 0;
    localparam int EV_REJ  = 1;
    localparam int EV_LOCK = 2;
    localparam int EV_MARK = 3;
    localparam int EV_N    = 4;

    // sources
    localparam logic [2:0] SRC_INT = 3'h0;

    // input states
    localparam logic [1:0] ST_NOLOCK = 2'h0;
    localparam logic [1:0] ST_LOCK   = 2'h1;
    localparam logic [1:0] ST_SYNC   = 2'h2;

    // rates and steps
    localparam logic [17:0] RATE_RST     = 18'h0_ac44;
    localparam logic [17:0] RATE_DBL_HZ  = 18'h1_5888;
    localparam logic [17:0] RATE_QUAD_HZ = 18'h2_b110;
    localparam logic signed [18:0] COARSE_HZ = 19'sh0_0032;
    localparam logic signed [18:0] FINE_HZ   = 19'sh0_0001;
    // fractions of the rate, scaled by 2^16
    localparam logic [11:0] MUL_5PCT   = 12'hccd;
    localparam logic [11:0] MUL_0P1PCT = 12'h042;
    localparam logic [11:0] MUL_4PCT   = 12'ha3d;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wck_out_en;
        logic       tms;
        logic       single_speed;
        logic       coax_pro;
        logic       opt_spdif;
        logic [2:0] src;
    } ctrl_t;
    localparam ctrl_t CTRL_RST = '{default: '0};

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [1:0] marker;
        logic [7:0] spdif_cs;
        logic [7:0] aes_cs;
    } rx_t;

endpackage

/* File: sample_clock_select.sv */
// sample clock selector: source choice with fallback, input status, dds pitch,
// word clock output and digital output format bits behind an apb slave.
// assumes pins are asynchronous to pclk; rx and stream_active come from pclk logic.
module sample_clock_select
    import sample_clock_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire apb_req_t    apb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic  [3:0] lock_pin,
    input  wire logic  [3:0] sync_pin,
    input  wire logic  [3:0] wclk_pin,
    input  wire rx_t         rx,
    input  wire logic        stream_active,
    output logic             sample_strobe,
    output logic             wck_out,
    output logic             bnc_out,
    output logic             bnc_oe,
    output logic             opt_spdif_mode,
    output logic             opt_cs_pro,
    output logic             coax_cs_pro,
    output logic       [2:0] cur_source,
    output logic             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        ctrl_t                     ctrl;
        logic [17:0]               rate;
        logic signed [18:0]        ofs;
        logic [39:0]               acc;
        logic [3:0][2:0]           p_lock;
        logic [3:0][2:0]           p_sync;
        logic [3:0][2:0]           p_wclk;
        logic [3:0]                lock_q;
        logic [3:0]                sync_q;
        logic [3:0]                wclk_q;
        logic [3:0][CNT_W-1:0]     per_cnt;
        logic [3:0][2:0]           cls;
        logic                      base_prev;
        logic [1:0]                div;
        logic                      wck;
        logic                      strobe;
        logic                      bnc_oe;
        logic                      opt_spdif;
        logic                      opt_pro;
        logic                      coax_pro;
        logic [2:0]                cur;
        rx_t                       cstat;
        logic [EV_N-1:0]           ist;
        logic [EV_N-1:0]           ien;
        logic                      irq;
        logic [31:0]               prdata;
        logic                      pready;
        logic                      pslverr;
    } state_t;

    state_t st;
    state_t next_st;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] classify(input logic [CNT_W-1:0] c);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 6; i >= 0; i--) begin
            if (c < CLS_CYC[i]) begin
                r = 3'(7 - i);
            end
        end
        return r;
    endfunction

    function automatic logic signed [18:0] frac(input logic [17:0] r, input logic [11:0] m);
        logic [29:0] p;
        p = 30'(r) * 30'(m);
        return $signed(19'(p >> 16));
    endfunction

    logic               setup;
    logic               access;
    logic               wr;
    logic signed [18:0] lim;
    logic signed [18:0] cand;
    logic [19:0]        freq;
    logic               master;
    logic               base;
    logic               quad;
    logic               dbl;
    logic [2:0]         sel;
    logic [2:0]         cls_now;
    logic [19:0]        in_stat;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        setup   = apb.psel && !apb.penable;
        access  = apb.psel && apb.penable && st.pready;
        wr      = access && apb.pwrite;

        // three-stage pin synchronisers; a change counts when stages two and three agree
        for (int i = 0; i < 4; i++) begin
            next_st.p_lock[i] = {st.p_lock[i][1:0], lock_pin[i]};
            next_st.p_sync[i] = {st.p_sync[i][1:0], sync_pin[i]};
            next_st.p_wclk[i] = {st.p_wclk[i][1:0], wclk_pin[i]};
            if (st.p_lock[i][1] == st.p_lock[i][2]) begin
                next_st.lock_q[i] = st.p_lock[i][2];
            end
            if (st.p_sync[i][1] == st.p_sync[i][2]) begin
                next_st.sync_q[i] = st.p_sync[i][2];
            end
            if (st.p_wclk[i][1] == st.p_wclk[i][2]) begin
                next_st.wclk_q[i] = st.p_wclk[i][2];
            end
            // period between rising edges gives the coarse rate
            if (!st.lock_q[i]) begin
                next_st.cls[i]     = 3'h0;
                next_st.per_cnt[i] = '0;
            end else if (next_st.wclk_q[i] && !st.wclk_q[i]) begin
                next_st.cls[i]     = classify(st.per_cnt[i]);
                next_st.per_cnt[i] = '0;
            end else if (st.per_cnt[i] != '1) begin
                next_st.per_cnt[i] = st.per_cnt[i] + CNT_W'(1);
            end
        end

        // source choice with fallback in input order after the chosen one
        next_st.cur = SRC_INT;
        sel         = st.ctrl.src;
        if (sel != SRC_INT && sel <= 3'h4) begin
            if (st.lock_q[2'(sel - 3'h1)]) begin
                next_st.cur = sel;
            end else begin
                for (int k = 3; k >= 1; k--) begin
                    if (st.lock_q[2'(sel - 3'h1 + 3'(k))]) begin
                        next_st.cur = 3'(2'(sel - 3'h1 + 3'(k))) + 3'h1;
                    end
                end
            end
        end

        // dds runs at the sample rate; pitch only when the unit is master
        master = (st.cur == SRC_INT);
        freq   = master ? 20'($signed({2'b00, st.rate}) + st.ofs) : {2'b00, st.rate};
        next_st.acc = st.acc + 40'(freq * DDS_GAIN);

        // word clock: in use rate, or base rate when single speed is set
        base    = master ? st.acc[39] : st.wclk_q[2'(st.cur - 3'h1)];
        cls_now = master ? 3'h0 : st.cls[2'(st.cur - 3'h1)];
        quad    = master ? (st.rate >= RATE_QUAD_HZ) : (cls_now >= 3'h6);
        dbl     = master ? (st.rate >= RATE_DBL_HZ) : (cls_now >= 3'h4);
        next_st.base_prev = base;
        next_st.strobe    = base && !st.base_prev;
        if (base && !st.base_prev) begin
            next_st.div = st.div + 2'h1;
        end
        if (!st.ctrl.single_speed) begin
            next_st.wck = base;
        end else if (quad) begin
            next_st.wck = st.div[1];
        end else if (dbl) begin
            next_st.wck = st.div[0];
        end else begin
            next_st.wck = base;
        end

        // output format bits
        next_st.bnc_oe    = st.ctrl.wck_out_en;
        next_st.opt_spdif = st.ctrl.opt_spdif;
        next_st.opt_pro   = 1'b0;
        next_st.coax_pro  = st.ctrl.coax_pro;
        next_st.cstat     = st.ctrl.tms ? rx : '0;

        // pitch offset, clamped to five percent of the base rate
        lim  = frac(st.rate, MUL_5PCT);
        cand = st.ofs;
        if (wr && apb.paddr == ADDR_PITCH) begin
            cand = $signed(apb.pwdata[18:0]);
        end
        if (wr && apb.paddr == ADDR_PCMD) begin
            if (apb.pwdata[PC_COARSE_UP]) begin
                cand = st.ofs + COARSE_HZ;
            end else if (apb.pwdata[PC_COARSE_DN]) begin
                cand = st.ofs - COARSE_HZ;
            end else if (apb.pwdata[PC_FINE_UP]) begin
                cand = st.ofs + FINE_HZ;
            end else if (apb.pwdata[PC_FINE_DN]) begin
                cand = st.ofs - FINE_HZ;
            end else if (apb.pwdata[PC_RESET]) begin
                cand = '0;
            end else if (apb.pwdata[PC_UP_0P1]) begin
                cand = frac(st.rate, MUL_0P1PCT);
            end else if (apb.pwdata[PC_DN_0P1]) begin
                cand = -frac(st.rate, MUL_0P1PCT);
            end else if (apb.pwdata[PC_UP_4]) begin
                cand = frac(st.rate, MUL_4PCT);
            end else if (apb.pwdata[PC_DN_4]) begin
                cand = -frac(st.rate, MUL_4PCT);
            end
        end
        // clamp every cycle so a lower rate also narrows a held offset
        if (cand > lim) begin
            next_st.ofs = lim;
        end else if (cand < -lim) begin
            next_st.ofs = -lim;
        end else begin
            next_st.ofs = cand;
        end

        // register writes
        if (wr && apb.paddr == ADDR_CTRL) begin
            next_st.ctrl = ctrl_t'(apb.pwdata[7:0]);
        end
        if (wr && apb.paddr == ADDR_RATE && !stream_active) begin
            next_st.rate = apb.pwdata[17:0];
        end
        if (wr && apb.paddr == ADDR_IEN) begin
            next_st.ien = apb.pwdata[EV_N-1:0];
        end

        // sticky events; a set in the clearing cycle wins
        if (wr && apb.paddr == ADDR_ICLR) begin
            next_st.ist = st.ist & ~apb.pwdata[EV_N-1:0];
        end
        if (next_st.cur != st.cur) begin
            next_st.ist[EV_SRC] = 1'b1;
        end
        if (wr && apb.paddr == ADDR_RATE && stream_active) begin
            next_st.ist[EV_REJ] = 1'b1;
        end
        if (next_st.lock_q != st.lock_q) begin
            next_st.ist[EV_LOCK] = 1'b1;
        end
        if (st.ctrl.tms && |rx.marker) begin
            next_st.ist[EV_MARK] = 1'b1;
        end
        next_st.irq = |(st.ist & st.ien);

        // input status words: state in bits 1:0, rate class in bits 4:2
        for (int i = 0; i < 4; i++) begin
            in_stat[i*5 +: 2] = !st.lock_q[i] ? ST_NOLOCK :
                                (st.sync_q[i] ? ST_SYNC : ST_LOCK);
            in_stat[i*5+2 +: 3] = st.cls[i];
        end

        // apb: data and ready registered in setup, one access cycle, no waits
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = 32'h0000_0000;
        if (setup) begin
            case (apb.paddr)
                ADDR_CTRL: begin
                    next_st.prdata = {24'h00_0000, st.ctrl};
                end
                ADDR_RATE: begin
                    next_st.prdata = {14'h0000, st.rate};
                end
                ADDR_PITCH: begin
                    next_st.prdata = {{13{st.ofs[18]}}, st.ofs};
                end
                ADDR_INPUT: begin
                    next_st.prdata = {12'h000, in_stat};
                end
                ADDR_CUR: begin
                    next_st.prdata = {29'h0000_0000, st.cur};
                end
                ADDR_CSTAT: begin
                    next_st.prdata = {14'h0000, st.cstat};
                end
                ADDR_IST: begin
                    next_st.prdata = {28'h000_0000, st.ist};
                end
                ADDR_IEN: begin
                    next_st.prdata = {28'h000_0000, st.ien};
                end
                ADDR_PCMD, ADDR_ICLR: begin
                    next_st.prdata = 32'h0000_0000;
                end
                default: begin
                    next_st.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= '0;
            st.ctrl <= CTRL_RST;
            st.rate <= RATE_RST;
        end else begin
            st <= next_st;
        end
    end

    assign prdata         = st.prdata;
    assign pready         = st.pready;
    assign pslverr        = st.pslverr;
    assign sample_strobe  = st.strobe;
    assign wck_out        = st.wck;
    assign bnc_out        = st.wck;
    assign bnc_oe         = st.bnc_oe;
    assign opt_spdif_mode = st.opt_spdif;
    assign opt_cs_pro     = st.opt_pro;
    assign coax_cs_pro    = st.coax_pro;
    assign cur_source     = st.cur;
    assign irq            = st.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_setup;
        apb.psel && !apb.penable;
    endsequence

    sequence s_rate_wr;
        apb.psel && apb.penable && pready && apb.pwrite && apb.paddr == ADDR_RATE;
    endsequence

    chk_apb_answer: assert property (s_setup |=> pready)
        else $error("apb access phase not ready");

    chk_rate_refused: assert property (s_rate_wr ##0 stream_active |=> $stable(st.rate) ##0 st.ist[EV_REJ])
        else $error("rate changed while streaming");

    chk_all_unlocked: assert property (st.lock_q == 4'h0 |=> cur_source == SRC_INT)
        else $error("no lock but external source in use");

    chk_chosen_return: assert property (st.ctrl.src != SRC_INT && st.ctrl.src <= 3'h4 && st.lock_q[2'(st.ctrl.src - 3'h1)] |=> cur_source == $past(st.ctrl.src))
        else $error("locked chosen source not used");

    chk_pitch_master: assert property (cur_source != SRC_INT |-> freq == {2'b00, st.rate})
        else $error("pitch applied in slave mode");

    chk_pitch_range: assert property ($stable(st.rate) |-> st.ofs <= frac(st.rate, MUL_5PCT) && st.ofs >= -frac(st.rate, MUL_5PCT))
        else $error("pitch offset outside range");

    chk_bnc_drive: assert property ($rose(st.ctrl.wck_out_en) |=> bnc_oe ##0 bnc_out == wck_out)
        else $error("connector not driven");

    chk_tms_block: assert property (!st.ctrl.tms ##1 (s_setup ##0 (!st.ctrl.tms && apb.paddr == ADDR_CSTAT)) |=> prdata == 32'h0000_0000)
        else $error("status forwarded while disabled");

    chk_opt_consumer: assert property (opt_spdif_mode |-> !opt_cs_pro)
        else $error("optical spdif marked professional");

    chk_irq_level: assert property (irq == $past(|(st.ist & st.ien)))
        else $error("interrupt not raised");

    chk_input_code: assert property (s_setup ##0 (apb.paddr == ADDR_INPUT && !st.lock_q[3]) |=> prdata[16:15] == ST_NOLOCK)
        else $error("unlocked input not reported");

endmodule

/* File: audio_source_model.sv */
// behavioural far side: four digital sources with lock, sync and frame clock
// assumes the bench steers lock, sync and frame rate with levels set on pclk edges
module audio_source_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic  [3:0] want_lock,
    input  wire logic  [3:0] want_sync,
    input  wire logic [15:0] half_cyc,
    output logic       [3:0] lock_pin,
    output logic       [3:0] sync_pin,
    output logic       [3:0] wclk_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt;
    logic        phase;
    // an unlocked source's frame clock chatters every cycle so no stale level looks valid; its lock and sync stay low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= '0;
            phase    <= 1'b0;
            lock_pin <= '0;
            sync_pin <= '0;
            wclk_pin <= '0;
        end else begin
            cnt      <= (cnt + 16'h0001 >= half_cyc) ? 16'h0000 : cnt + 16'h0001;
            phase    <= (cnt + 16'h0001 >= half_cyc) ? ~phase : phase;
            lock_pin <= want_lock;
            sync_pin <= want_sync & want_lock;
            wclk_pin <= (want_lock & {4{phase}}) | (~want_lock & ~wclk_pin);
        end
    end
endmodule

/* File: sample_clock_select_bench.sv */
// self-checking bench for the sample clock selector, random settings from a fixed seed
// assumes the source model on the pins and one 125 MHz clock
module sample_clock_select_bench
    import sample_clock_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, stream_active = 0, err, pready, pslverr;
    logic sample_strobe, wck_out, bnc_out, bnc_oe, opt_spdif_mode, opt_cs_pro, coax_cs_pro, irq;
    logic [31:0] prdata, rd, d;
    logic [3:0] want_lock = '0, want_sync = '0, lock_pin, sync_pin, wclk_pin;
    logic [15:0] half_cyc = 16'h0589;
    logic [2:0] cur_source;
    logic signed [18:0] p;
    apb_req_t apb = '0;
    rx_t rx = '0;
    int fail_count = 0, total_checks = 0, i, c;
    int seq [11] = '{0, 2, 4, 5, 6, 8, 8, 8, 7, 1, 3};
    always #4 pclk = ~pclk;
    sample_clock_select sample_clock_select_inst (.pclk(pclk), .presetn(presetn), .apb(apb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .lock_pin(lock_pin),
        .sync_pin(sync_pin), .wclk_pin(wclk_pin), .rx(rx), .stream_active(stream_active),
        .sample_strobe(sample_strobe), .wck_out(wck_out), .bnc_out(bnc_out), .bnc_oe(bnc_oe),
        .opt_spdif_mode(opt_spdif_mode), .opt_cs_pro(opt_cs_pro), .coax_cs_pro(coax_cs_pro),
        .cur_source(cur_source), .irq(irq));
    audio_source_model audio_source_model_inst (.pclk(pclk), .presetn(presetn),
        .want_lock(want_lock), .want_sync(want_sync), .half_cyc(half_cyc),
        .lock_pin(lock_pin), .sync_pin(sync_pin), .wclk_pin(wclk_pin));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int n;
        @(posedge pclk);
        apb <= '{1'b1, 1'b0, w, a, dat};
        @(posedge pclk);
        apb.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        apb <= '0;
        if (n >= 20) begin
            fail_count++;
            stop_test();
        end
    endtask
    // lock and rate class need a few input periods, so poll within a bound
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            xfer(1'b0, a, 32'h0000_0000);
            n++;
        end while ((rd & m) !== e && n < 3000);
        chk("polled_reg", e, rd & m);
        if (n >= 3000) stop_test();
    endtask
    // first rise is skipped: the dds may still be settling on the new rate
    task automatic meas(input int e, input int ns);
        int n, k, t, s, b;
        logic q;
        k = 0;
        t = 0;
        s = 0;
        b = 0;
        q = wck_out;
        for (n = 0; n < 12000 && k < 3; n++) begin
            @(posedge pclk);
            s += (sample_strobe === 1'b1);
            b += (bnc_out !== wck_out);
            if (wck_out === 1'b1 && q === 1'b0) begin
                k++;
                t = (k == 3) ? n - t : n;
                s = (k == 2) ? 0 : s;
            end
            q = wck_out;
        end
        chk("wck_period", e, (k == 3 && t >= e - 2 && t <= e + 2) ? e : t);
        chk("strobe_count", ns, s);
        chk("bnc_out", 0, b);
        if (k < 3) begin
            fail_count++;
            stop_test();
        end
    endtask
    function automatic logic signed [18:0] step(input logic signed [18:0] v0, input int k);
        int v, lim;
        lim = (48000 * 3277) >>> 16;
        case (k)
            0: v = v0 + 50;
            1: v = v0 - 50;
            2: v = v0 + 1;
            3: v = v0 - 1;
            4: v = 0;
            5: v = (48000 * 66) >>> 16;
            6: v = -((48000 * 66) >>> 16);
            7: v = (48000 * 2621) >>> 16;
            default: v = -((48000 * 2621) >>> 16);
        endcase
        v = (v > lim) ? lim : ((v < -lim) ? -lim : v);
        return 19'(v);
    endfunction
    initial begin
        void'($urandom(73159));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, ADDR_RATE, 32'h0000_0000);
        chk("rate_reset", 32'h0000_ac44, rd);
        chk("cur_reset", 32'h0000_0000, cur_source);
        xfer(1'b0, 8'h28, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, err);
        for (i = 0; i < 6; i++) begin
            d = $urandom & 32'h0000_00f8;
            xfer(1'b1, ADDR_CTRL, d);
            repeat (2) @(posedge pclk);
            chk("opt_spdif_mode", d[3], opt_spdif_mode);
            chk("opt_cs_pro", 32'h0000_0000, opt_cs_pro);
            chk("coax_cs_pro", d[4], coax_cs_pro);
            chk("bnc_oe", d[7], bnc_oe);
        end
        rx <= 18'($urandom);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
        xfer(1'b0, ADDR_CSTAT, 32'h0000_0000);
        chk("cstat_off", 32'h0000_0000, rd);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0040);
        xfer(1'b0, ADDR_CSTAT, 32'h0000_0000);
        chk("cstat_on", {14'h0000, rx}, rd);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0000);
        xfer(1'b1, ADDR_IEN, 32'h0000_0002);
        stream_active <= 1'b1;
        xfer(1'b1, ADDR_RATE, 32'h0000_bb80);
        stream_active <= 1'b0;
        xfer(1'b0, ADDR_RATE, 32'h0000_0000);
        chk("rate_kept", 32'h0000_ac44, rd);
        chk("irq_set", 32'h0000_0001, irq);
        xfer(1'b1, ADDR_IEN, 32'h0000_0000);
        repeat (2) @(posedge pclk);
        chk("irq_masked", 32'h0000_0000, irq);
        xfer(1'b1, ADDR_ICLR, 32'h0000_0002);
        xfer(1'b0, ADDR_IST, 32'h0000_0000);
        chk("ist_clear", 32'h0000_0000, rd & 32'h0000_0002);
        xfer(1'b1, ADDR_RATE, 32'h0000_bb80);
        p = 0;
        for (i = 0; i < 24; i++) begin
            c = (i < 11) ? seq[i] : $urandom_range(8);
            xfer(1'b1, ADDR_PCMD, 32'h0000_0001 << c);
            p = step(p, c);
            xfer(1'b0, ADDR_PITCH, 32'h0000_0000);
            chk("pitch", {{13{p[18]}}, p}, rd);
        end
        meas(125000000 / (48000 + p), 1);
        xfer(1'b1, ADDR_PCMD, 32'h0000_0010);
        meas(2604, 1);
        xfer(1'b1, ADDR_RATE, 32'h0001_7700);
        meas(1302, 1);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0020);
        meas(2604, 2);
        xfer(1'b1, ADDR_RATE, 32'h0002_ee00);
        meas(2604, 4);
        xfer(1'b1, ADDR_CTRL, 32'h0000_0001);
        want_lock <= 4'b0100;
        want_sync <= 4'b0100;
        poll(ADDR_CUR, 32'h0000_0007, 32'h0000_0003);
        chk("cur_source", 32'h0000_0003, cur_source);
        want_lock <= 4'b0101;
        poll(ADDR_CUR, 32'h0000_0007, 32'h0000_0001);
        poll(ADDR_INPUT, 32'h0001_fc7f, 32'h0000_2809);
        meas(2834, 1);
        xfer(1'b1, ADDR_ICLR, 32'h0000_0001);
        want_lock <= 4'b0000;
        poll(ADDR_CUR, 32'h0000_0007, 32'h0000_0000);
        xfer(1'b0, ADDR_IST, 32'h0000_0000);
        chk("ist_source", 32'h0000_0001, rd & 32'h0000_0001);
        stop_test();
    end
endmodule
